// [rtl/acs_sequencer.sv]
// Conversion sequencer: control byte, clock and acquisition modes, power-down, result latch.
// Assumes host strobes and the external conversion clock are synchronous to clk;
// the analog SAR delivers sar_result at the end of twelve conversion-clock cycles.
//
// Notes on behaviour
// - End-of-conversion flag goes low when a result is ready.
// - Flag returns high on first read or on a new control-byte write.
// - Top two bits choose clock mode; power-down codes keep previous clock mode.
// - Bit7=0, bit6=1 selects internal conversion clock.
// - Bit7=0, bit6=0 selects external conversion clock.
// - Both acquisition methods work identically with either clock.
// - Reset sets flag high, normal operation, external clock.
// - Power-down takes effect only after the conversion started by the power-down write completes.
// - Bus interface stays usable in power-down; result readable.
// - Write strobe falling edge during write leaves power-down.
// - Standby keeps bandgap and buffer on; full keeps only bandgap.
// - Unipolar results straight binary, bipolar twos complement, 4096 steps.
// - Power-select 00 ext, 01 int, 10 standby, 11 full power-down.
// - Every conversion takes exactly twelve conversion-clock cycles.
// - Control write during conversion aborts it and restarts acquisition.
// - Bit 3 clear is unipolar, set is bipolar coding.
`timescale 1ns/1ns
`default_nettype none
module acs_sequencer #(
  parameter int INT_CLK_DIV = acs_pkg::INT_CLK_DIV_DEFAULT
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic chip_select_n,
  input wire logic write_n,
  input wire logic read_n,
  input wire logic [7:0] data_in,
  output logic [11:0] data_out,
  output logic data_oe,
  input wire logic ext_conv_clk,
  input wire logic [11:0] sar_result,
  output logic end_of_conv_n,
  output logic internal_clock_mode,
  output logic track,
  output logic converting,
  output logic bandgap_enable,
  output logic buffer_enable,
  output logic standby_powerdown,
  output logic full_powerdown,
  output logic polarity_select,
  output logic range_select,
  output logic [2:0] channel
);
  import acs_pkg::*;

  // ----------------------------------------------------------------------
  // Host strobes
  // ----------------------------------------------------------------------
  logic wr_q;
  logic rd_q;
  logic wr_active;
  logic rd_active;
  logic wr_fall;
  logic wr_rise;
  logic rd_fall;

  assign wr_active = !chip_select_n && !write_n;
  assign rd_active = !chip_select_n && !read_n;
  assign wr_fall = wr_active && !wr_q;
  assign wr_rise = !wr_active && wr_q;
  assign rd_fall = rd_active && !rd_q;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end
    else
    begin
      wr_q <= wr_active;
      rd_q <= rd_active;
    end
  end

  // ----------------------------------------------------------------------
  // Control byte and modes
  // ----------------------------------------------------------------------
  logic [7:0] ctl;
  logic acquisition_select;
  logic power_select_hi;
  logic power_select_lo;
  logic pd_request;
  logic pd_pending;
  logic pd_full;

  assign acquisition_select = ctl[CTL_ACQ_BIT];
  assign power_select_hi = data_in[CTL_POWER_HI_BIT];
  assign power_select_lo = data_in[CTL_POWER_LO_BIT];

  // Byte is latched at the rising edge, which is where the write completes.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ctl <= CTL_RESET;
    end
    else if (wr_rise)
    begin
      ctl <= data_in;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      internal_clock_mode <= 1'b0;
    end
    else if (wr_rise && !power_select_hi)
    begin
      internal_clock_mode <= power_select_lo;
    end
  end

  assign polarity_select = ctl[CTL_POLARITY_BIT];
  assign range_select = ctl[CTL_RANGE_BIT];
  assign channel = ctl[CTL_CHAN_MSB:0];

  // ----------------------------------------------------------------------
  // Conversion clock
  // ----------------------------------------------------------------------
  logic int_tick;
  logic ext_q;
  logic conv_tick;
  logic powered;

  acs_clock_divider #(
    .DIV(INT_CLK_DIV)
  ) u_osc (
    .clk(clk),
    .reset(reset),
    .run(internal_clock_mode && powered),
    .tick(int_tick)
  );

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ext_q <= 1'b0;
    end
    else
    begin
      ext_q <= ext_conv_clk;
    end
  end

  // One tick source feeds the same sequencer either way.
  assign conv_tick = internal_clock_mode ? int_tick : (ext_conv_clk && !ext_q);

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  acs_state_e state;
  logic [3:0] count;
  logic done;

  assign done = (state == ACS_CONVERT) && conv_tick && (count == CONV_CYCLES - 4'h1);

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state <= ACS_IDLE;
      count <= 4'h0;
    end
    else if (wr_rise)
    begin
      count <= 4'h0;
      if (data_in[CTL_ACQ_BIT] || state != ACS_ACQUIRE || ctl[CTL_ACQ_BIT] == 1'b0)
      begin
        state <= ACS_ACQUIRE;
      end
      else
      begin
        // Second write of an externally timed acquisition starts conversion.
        state <= ACS_CONVERT;
      end
    end
    else
    begin
      case (state)
        ACS_IDLE:
        begin
          count <= 4'h0;
        end
        ACS_ACQUIRE:
        begin
          if (!acquisition_select && conv_tick)
          begin
            if (count == ACQ_CYCLES - 4'h1)
            begin
              count <= 4'h0;
              state <= ACS_CONVERT;
            end
            else
            begin
              count <= count + 4'h1;
            end
          end
        end
        ACS_CONVERT:
        begin
          if (done)
          begin
            count <= 4'h0;
            state <= ACS_IDLE;
          end
          else if (conv_tick)
          begin
            count <= count + 4'h1;
          end
        end
        default:
        begin
          state <= ACS_IDLE;
          count <= 4'h0;
        end
      endcase
    end
  end

  assign track = (state == ACS_ACQUIRE);
  assign converting = (state == ACS_CONVERT);

  // ----------------------------------------------------------------------
  // Result latch and flag
  // ----------------------------------------------------------------------
  logic [11:0] result;

  // Bipolar SAR output is offset binary; flipping the top bit gives twos complement.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      result <= 12'h000;
    end
    else if (done)
    begin
      result <= polarity_select ? (sar_result ^ BIPOLAR_OFFSET) : sar_result;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      end_of_conv_n <= 1'b1;
    end
    else if (done)
    begin
      end_of_conv_n <= 1'b0;
    end
    else if (rd_fall || wr_fall)
    begin
      end_of_conv_n <= 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      data_out <= 12'h000;
    end
    else
    begin
      data_out <= result;
    end
  end

  assign data_oe = rd_active;

  // ----------------------------------------------------------------------
  // Power-down
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pd_pending <= 1'b0;
      pd_full <= 1'b0;
    end
    else if (wr_rise)
    begin
      pd_pending <= power_select_hi;
      pd_full <= power_select_lo;
    end
    else if (wr_fall)
    begin
      // A waking write drops the old request, or the device would sleep again before its byte lands.
      pd_pending <= 1'b0;
    end
  end

  assign pd_request = pd_pending && (state == ACS_IDLE);

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      powered <= 1'b1;
    end
    else if (wr_fall)
    begin
      powered <= 1'b1;
    end
    else if (pd_request)
    begin
      powered <= 1'b0;
    end
  end

  assign standby_powerdown = !powered && !pd_full;
  assign full_powerdown = !powered && pd_full;
  assign bandgap_enable = 1'b1;
  assign buffer_enable = !full_powerdown;

  // Counts conversion-clock ticks apart from the sequencer's own counter.
  logic [3:0] seen_ticks;

  always_ff @(posedge clk)
  begin
    if (reset || !converting)
    begin
      seen_ticks <= 4'h0;
    end
    else if (conv_tick)
    begin
      seen_ticks <= seen_ticks + 4'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  flag_on_done_a: assert property (@(posedge clk) disable iff (reset) done |=> !end_of_conv_n)
    else $error("flag not low after conversion end");
  flag_release_a: assert property (@(posedge clk) disable iff (reset)
    (!end_of_conv_n && rd_fall && !done) |=> end_of_conv_n)
    else $error("flag not released by read");
  clock_keep_a: assert property (@(posedge clk) disable iff (reset)
    (wr_rise && power_select_hi) |=> $stable(internal_clock_mode))
    else $error("power-down write changed clock mode");
  clock_int_a: assert property (@(posedge clk) disable iff (reset)
    (wr_rise && !power_select_hi && power_select_lo) |=> internal_clock_mode)
    else $error("internal clock not selected");
  clock_ext_a: assert property (@(posedge clk) disable iff (reset)
    (wr_rise && !power_select_hi && !power_select_lo) |=> !internal_clock_mode)
    else $error("external clock not selected");
  pd_wait_a: assert property (@(posedge clk) disable iff (reset)
    (converting && powered && !wr_rise) |=> powered)
    else $error("powered down during conversion");
  wake_write_a: assert property (@(posedge clk) disable iff (reset) wr_fall |=> powered)
    else $error("write did not wake device");
  buffer_mode_a: assert property (@(posedge clk) disable iff (reset)
    standby_powerdown |-> (buffer_enable && bandgap_enable))
    else $error("standby disabled reference buffer");
  abort_conv_a: assert property (@(posedge clk) disable iff (reset) (converting && wr_rise) |=> track)
    else $error("write did not abort conversion");
  result_hold_a: assert property (@(posedge clk) disable iff (reset) !done |=> $stable(result))
    else $error("result changed without conversion");
  conv_len_a: assert property (@(posedge clk) disable iff (reset) done |-> seen_ticks == CONV_CYCLES - 4'h1)
    else $error("conversion length wrong");

  conv_done_c: cover property (@(posedge clk) done);
  standby_c: cover property (@(posedge clk) standby_powerdown);
  full_pd_c: cover property (@(posedge clk) full_powerdown);
  int_conv_c: cover property (@(posedge clk) done && internal_clock_mode);
endmodule // acs_sequencer
`default_nettype wire

// [rtl/acs_pkg.sv]
// Package for the conversion sequencer: control-byte layout, mode codes and counts.
// Assumes a single 50 MHz system clock shared by every file that imports it.
package acs_pkg;

  // ----------------------------------------------------------------------
  // Control-byte fields
  // ----------------------------------------------------------------------
  localparam int CTL_POWER_HI_BIT = 7;
  localparam int CTL_POWER_LO_BIT = 6;
  localparam int CTL_ACQ_BIT = 5;
  localparam int CTL_RANGE_BIT = 4;
  localparam int CTL_POLARITY_BIT = 3;
  localparam int CTL_CHAN_MSB = 2;

  // ----------------------------------------------------------------------
  // Power-select codes
  // ----------------------------------------------------------------------
  localparam logic [1:0] PSEL_NORMAL_EXT = 2'h0;
  localparam logic [1:0] PSEL_NORMAL_INT = 2'h1;
  localparam logic [1:0] PSEL_STANDBY = 2'h2;
  localparam logic [1:0] PSEL_FULL = 2'h3;

  // ----------------------------------------------------------------------
  // Counts and reset values
  // ----------------------------------------------------------------------
  localparam int RESULT_BITS = 12;
  localparam logic [3:0] CONV_CYCLES = 4'hc;
  localparam logic [3:0] ACQ_CYCLES = 4'h6;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [11:0] BIPOLAR_OFFSET = 12'h800;
  localparam int CLK_MHZ = 50;
  localparam int INT_CLK_DIV_DEFAULT = 32;

  typedef enum logic [1:0] {
    ACS_IDLE,
    ACS_ACQUIRE,
    ACS_CONVERT
  } acs_state_e;

endpackage

// [rtl/acs_clock_divider.sv]
// Internal conversion-clock oscillator modelled as a divider of the system clock.
// Assumes synchronous active-high reset; tick is one system cycle wide.
`timescale 1ns/1ns
`default_nettype none
module acs_clock_divider #(
  parameter int DIV = 32
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic run,
  output logic tick
);
  import acs_pkg::*;

  logic [15:0] count;

  // Stopped while not running so power-down really halts the oscillator.
  always_ff @(posedge clk)
  begin
    if (reset || !run)
    begin
      count <= 16'h0000;
      tick <= 1'b0;
    end
    else if (count == 16'(DIV - 1))
    begin
      count <= 16'h0000;
      tick <= 1'b1;
    end
    else
    begin
      count <= count + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule // acs_clock_divider
`default_nettype wire

// [tb/acs_host.sv]
// Host processor model on the parallel control bus of the conversion sequencer.
// Assumes the bench owns clk; the external conversion clock runs free from here.
`timescale 1ns/1ns
`default_nettype none
module acs_host #(
  parameter int EXT_HALF = 13
) (
  input wire logic clk,
  input wire logic [11:0] data_out,
  input wire logic data_oe,
  output logic chip_select_n,
  output logic write_n,
  output logic read_n,
  output logic [7:0] data_in,
  output logic ext_conv_clk
);
  // ----------------------------------------------------------------------
  // External conversion clock
  // ----------------------------------------------------------------------
  // A half period of 13 cycles gives about 1.92 MHz at 50% duty.
  int half_cnt;
  logic [7:0] last_byte;

  initial
  begin
    chip_select_n = 1'b1;
    write_n = 1'b1;
    read_n = 1'b1;
    data_in = 8'h00;
    ext_conv_clk = 1'b0;
    half_cnt = 0;
    last_byte = 8'h00;
  end

  always @(posedge clk)
  begin
    if (half_cnt == EXT_HALF - 1)
    begin
      half_cnt <= 0;
      ext_conv_clk <= ~ext_conv_clk;
    end
    else
      half_cnt <= half_cnt + 1;
  end

  // ----------------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------------
  task automatic wr_begin(input logic [7:0] b);
    @(posedge clk);
    chip_select_n <= 1'b0;
    write_n <= 1'b0;
    data_in <= b;
    last_byte = b;
  endtask

  // The byte stands through the edge at which the device sees the strobe high, since that edge latches it.
  // Afterwards the lines show the inverse so a stale byte is never mistaken for a live one.
  task automatic wr_end();
    @(posedge clk);
    write_n <= 1'b1;
    chip_select_n <= 1'b1;
    @(posedge clk);
    data_in <= ~last_byte;
  endtask

  task automatic write_byte(input logic [7:0] b);
    wr_begin(b);
    wr_end();
  endtask

  task automatic read_word(output logic [11:0] w, output logic oe);
    @(posedge clk);
    chip_select_n <= 1'b0;
    read_n <= 1'b0;
    @(posedge clk);
    #1;
    w = data_out;
    oe = data_oe;
    @(posedge clk);
    read_n <= 1'b1;
    chip_select_n <= 1'b1;
  endtask
endmodule // acs_host
`default_nettype wire

// [tb/adc_conversion_sequencer_test.sv]
// Self-checking bench for the conversion sequencer with a host model on its bus.
// Assumes a 50 MHz clk and a shortened internal oscillator divider of 4.
`timescale 1ns/1ns
`default_nettype none
module adc_conversion_sequencer_test;
  import acs_pkg::*;
  localparam int DIV = 4;
  localparam int EXT_CYC = 26;
  logic clk;
  logic reset;
  logic [11:0] sar_result;
  logic ext_prev;
  wire logic cs_n, wr_n, rd_n, ext_clk, oe, eoc_n, icm, track, converting;
  wire logic bg_en, buf_en, stby, full, pol, rng;
  wire logic [7:0] din;
  wire logic [11:0] dout;
  wire logic [2:0] chan;
  int num_errors = 0;
  int checks = 0;

  always #10 clk = ~clk;

  // Level of the external clock one edge earlier, to spot its rising edges.
  always @(posedge clk)
    ext_prev <= ext_clk;

  acs_host u_acs_host (.clk(clk), .data_out(dout), .data_oe(oe), .chip_select_n(cs_n), .write_n(wr_n),
    .read_n(rd_n), .data_in(din), .ext_conv_clk(ext_clk));
  acs_sequencer #(.INT_CLK_DIV(DIV)) u_acs_sequencer (.clk(clk), .reset(reset), .chip_select_n(cs_n),
    .write_n(wr_n), .read_n(rd_n), .data_in(din), .data_out(dout), .data_oe(oe), .ext_conv_clk(ext_clk),
    .sar_result(sar_result), .end_of_conv_n(eoc_n), .internal_clock_mode(icm), .track(track),
    .converting(converting), .bandgap_enable(bg_en), .buffer_enable(buf_en), .standby_powerdown(stby),
    .full_powerdown(full), .polarity_select(pol), .range_select(rng), .channel(chan));

  // ----------------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------------
  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Counts conversion cycles and any power-down level seen while converting.
  // An expected cycle count of zero means the start is not tied to the clock phase: external ticks count then.
  task automatic wait_eoc(input int exp_cycles);
    int n;
    int k;
    int pd;
    n = 0;
    k = 0;
    pd = 0;
    for (int t = 0; t < 2000; t++)
    begin
      #1;
      if (converting === 1'b1)
        n++;
      if (converting === 1'b1 && ext_clk === 1'b1 && ext_prev === 1'b0)
        k++;
      if (converting === 1'b1 && (stby | full) !== 1'b0)
        pd++;
      if (eoc_n === 1'b0)
        break;
      @(posedge clk);
    end
    check("end_of_conv_n low", eoc_n, 12'h000);
    if (exp_cycles > 0)
      check("conversion cycles", 12'(n), 12'(exp_cycles));
    else
      check("conversion clock ticks", 12'(k), 12'(CONV_CYCLES));
    check("powerdown during conversion", 12'(pd), 12'h000);
  endtask

  task automatic read_expect(input logic [11:0] exp);
    logic [11:0] w;
    logic w_oe;
    u_acs_host.read_word(w, w_oe);
    check("read word", w, exp);
    check("data_oe", w_oe, 12'h001);
    @(posedge clk);
    #1;
    check("flag after read", eoc_n, 12'h001);
  endtask

  task automatic convert(input logic [7:0] b, input logic [11:0] raw, input int cyc, input logic [11:0] exp);
    sar_result <= raw;
    u_acs_host.write_byte(b);
    wait_eoc(cyc);
    read_expect(exp);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    check("flag at reset", eoc_n, 12'h001);
    check("clock mode at reset", icm, 12'h000);
    check("standby at reset", stby, 12'h000);
    check("full at reset", full, 12'h000);
    check("buffer at reset", buf_en, 12'h001);
  endtask

  task automatic t_internal();
    logic [11:0] w;
    logic w_oe;
    convert(8'h45, 12'habc, 12 * DIV, 12'habc);
    check("internal clock", icm, 12'h001);
    check("unipolar", pol, 12'h000);
    check("channel", chan, 12'h005);
    sar_result <= 12'h111;
    u_acs_host.read_word(w, w_oe);
    check("repeat read", w, 12'habc);
  endtask

  task automatic t_bipolar_ext();
    convert(8'h1b, 12'h123, 12 * EXT_CYC, 12'h923);
    check("external clock", icm, 12'h000);
    check("bipolar", pol, 12'h001);
    check("range", rng, 12'h001);
  endtask

  task automatic t_ext_acq();
    sar_result <= 12'h5a5;
    u_acs_host.write_byte(8'h21);
    repeat (40) @(posedge clk);
    #1;
    check("track held", track, 12'h001);
    check("no conversion yet", converting, 12'h000);
    check("external clock held", icm, 12'h000);
    // The conversion starts at the write, so its length is counted in external clock ticks.
    u_acs_host.write_byte(8'h01);
    wait_eoc(0);
    read_expect(12'h5a5);
  endtask

  task automatic t_abort();
    sar_result <= 12'h0f0;
    u_acs_host.write_byte(8'h40);
    for (int t = 0; t < 200 && converting !== 1'b1; t++)
      @(posedge clk);
    u_acs_host.write_byte(8'h40);
    @(posedge clk);
    #1;
    check("aborted", converting, 12'h000);
    check("new acquisition", track, 12'h001);
    wait_eoc(12 * DIV);
    read_expect(12'h0f0);
  endtask

  task automatic t_power();
    sar_result <= 12'h3c3;
    u_acs_host.write_byte(8'hc0);
    wait_eoc(12 * DIV);
    @(posedge clk);
    #1;
    check("full powerdown", full, 12'h001);
    check("buffer off", buf_en, 12'h000);
    check("bandgap on", bg_en, 12'h001);
    check("clock mode kept", icm, 12'h001);
    // A standby cycle follows full power-down to let the reference recover.
    u_acs_host.wr_begin(8'h80);
    @(posedge clk);
    #1;
    check("woken", full, 12'h000);
    check("flag released by write", eoc_n, 12'h001);
    u_acs_host.wr_end();
    wait_eoc(12 * DIV);
    @(posedge clk);
    #1;
    check("standby", stby, 12'h001);
    check("buffer on", buf_en, 12'h001);
    check("clock mode kept", icm, 12'h001);
    read_expect(12'h3c3);
    convert(8'h40, 12'hfff, 12 * DIV, 12'hfff);
    check("normal again", stby, 12'h000);
  endtask

  // ----------------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // The tests need about 1300 cycles; over fifteen times that means a hang.
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    report_and_stop();
  end

  initial
  begin
    clk = 1'b0;
    reset = 1'b1;
    sar_result = 12'h000;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_internal();
    t_bipolar_ext();
    t_ext_acq();
    t_abort();
    t_power();
    report_and_stop();
  end
endmodule // adc_conversion_sequencer_test
`default_nettype wire
